// File: pkg/pabov_pkg.sv
// shared constants for the port a / port b alternate function override block
`default_nettype none

package pabov_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned DUTY_W = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************************************
    // pin positions
    // ****************************************************************
    // port a: front-plane lines on 7..4, back-plane lines on 3..0
    localparam int unsigned FP_LO = 4;
    localparam int unsigned FP_HI = 7;
    // port b: compare outputs on 7..4, spi on 3..0
    localparam int unsigned PB_T2A = 7;
    localparam int unsigned PB_T1B = 6;
    localparam int unsigned PB_T1A = 5;
    localparam int unsigned PB_T0A = 4;
    localparam int unsigned PB_MISO = 3;
    localparam int unsigned PB_MOSI = 2;
    localparam int unsigned PB_SCK = 1;
    localparam int unsigned PB_SS = 0;

    // ****************************************************************
    // duty thresholds: back-plane n is used when duty select exceeds these
    // ****************************************************************
    localparam logic [DUTY_W-1:0] BP3_ABOVE = 2'h2;
    localparam logic [DUTY_W-1:0] BP2_ABOVE = 2'h1;
    localparam logic [DUTY_W-1:0] BP1_ABOVE = 2'h0;

    // ****************************************************************
    // reset values and warm-up end count
    // ****************************************************************
    localparam logic [PORT_W-1:0] SYNC_RST = 8'h00;
    localparam logic [1:0] WARM_RST = 2'h0;
    localparam logic [1:0] WARM_DONE = 2'h3;

endpackage

`default_nettype wire

// File: logic/pabov_pin_ctrl.sv
// generic per-pin override combiner: pull-up, driver, value and input enable
`timescale 1ns/10ps
`default_nettype none

module pabov_pin_ctrl #(
    parameter int unsigned W = 8
) (
    input wire logic [W-1:0] dir_i,
    input wire logic [W-1:0] out_i,
    input wire logic pullup_disable_all_i,
    input wire logic sleep_i,
    input wire logic [W-1:0] pullup_ovr_enable_i,
    input wire logic [W-1:0] pullup_ovr_value_i,
    input wire logic [W-1:0] dir_ovr_enable_i,
    input wire logic [W-1:0] dir_ovr_value_i,
    input wire logic [W-1:0] value_ovr_enable_i,
    input wire logic [W-1:0] value_ovr_value_i,
    input wire logic [W-1:0] input_en_ovr_enable_i,
    input wire logic [W-1:0] input_en_ovr_value_i,
    output logic [W-1:0] pull_en_o,
    output logic [W-1:0] drv_en_o,
    output logic [W-1:0] pad_val_o,
    output logic [W-1:0] in_en_o
);

    // ****************************************************************
    // bitwise select: override value where enabled, default elsewhere
    // ****************************************************************
    function automatic logic [W-1:0] ovr_sel(
        input logic [W-1:0] en,
        input logic [W-1:0] val,
        input logic [W-1:0] dflt
    );
        ovr_sel = (en & val) | (~en & dflt);
    endfunction

    // pull-up defaults to input-with-port-bit-high, unless globally off
    assign pull_en_o = ovr_sel(pullup_ovr_enable_i, pullup_ovr_value_i,
                               ~dir_i & out_i & {W{~pullup_disable_all_i}});

    // driver enable defaults to the direction bit
    assign drv_en_o = ovr_sel(dir_ovr_enable_i, dir_ovr_value_i, dir_i);

    // value only matters while the driver is on
    assign pad_val_o = ovr_sel(value_ovr_enable_i, value_ovr_value_i, out_i);

    // deep sleep clamps inputs unless an owner keeps them alive
    assign in_en_o = ovr_sel(input_en_ovr_enable_i, input_en_ovr_value_i,
                             {W{~sleep_i}});

endmodule

`default_nettype wire

// File: logic/pabov_top.sv
// port a / port b alternate function override logic with pad input synchronizers
// Operation
// - port a gives lcd four front-plane lines on 7..4, back-plane on 3..0
// - pins a7..4 with display on: pull, driver, input off, pad to front plane
// - pins a3,a2,a1 claimed only when duty exceeds 2,1,0; a0 whenever on
// - claimed back-plane pins: pull, driver, input off, pad to back plane
// - b7 carries timer2 compare a while its direction bit is set
// - b6 carries timer1 compare b while its direction bit is set
// - b5 carries timer1 compare a while its direction bit is set
// - b4 carries timer0 compare a while its direction bit is set
// - pins b7..4 also present the timers' pwm waveforms
// - port b pins 7..0 feed pin-change sources 15..8
// - spi master forces b3 to data input, ignoring its direction bit
// - spi slave: b3 direction follows its direction bit
// - b3 pull-up stays under its port bit while forced to input
// - b2,b1,b0 serve spi data, clock, select and pin-change 10,9,8
// - pull-up follows override, else on for input, port bit high, not disabled
// - driver follows override, else the direction bit
// - input enable follows override, else normal-or-sleep state
`timescale 1ns/10ps
`default_nettype none

module pabov_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sleep_i,
    input wire logic pullup_disable_all_i,
    input wire logic [7:0] port_a_dir_i,
    input wire logic [7:0] port_a_out_i,
    input wire logic [7:0] port_b_dir_i,
    input wire logic [7:0] port_b_out_i,
    input wire logic display_drive_on_i,
    input wire logic [1:0] display_duty_select_i,
    input wire logic [3:0] tmr_cmp_en_i,
    input wire logic timer2_cmp_a_out_i,
    input wire logic timer1_cmp_b_out_i,
    input wire logic timer1_cmp_a_out_i,
    input wire logic timer0_cmp_a_out_i,
    input wire logic spi_enable_i,
    input wire logic spi_master_i,
    input wire logic spi_slave_out_i,
    input wire logic spi_master_out_i,
    input wire logic spi_sck_out_i,
    input wire logic pin_change_group_en_i,
    input wire logic [7:0] pin_change_mask_i,
    input wire logic [7:0] pa_pad_i,
    input wire logic [7:0] pb_pad_i,
    output logic [7:0] pa_pad_o,
    output logic [7:0] pa_pad_oe_o,
    output logic [7:0] pa_pull_o,
    output logic [7:0] pa_in_en_o,
    output logic [7:0] analog_pad_link_o,
    output logic [7:0] pb_pad_o,
    output logic [7:0] pb_pad_oe_o,
    output logic [7:0] pb_pull_o,
    output logic [7:0] pb_in_en_o,
    output logic [7:0] pa_pin_o,
    output logic [7:0] pb_pin_o,
    output logic [7:0] pin_change_src_o,
    output logic spi_master_in_o,
    output logic spi_slave_in_o,
    output logic spi_sck_in_o,
    output logic spi_select_in_o
);

    localparam int unsigned W = pabov_pkg::PORT_W;

    // ****************************************************************
    // port a: lcd ownership
    // ****************************************************************
    logic [W-1:0] pa_claim;
    logic [W-1:0] pa_zero;

    // back-plane pins are claimed only as far as the duty needs commons
    assign pa_claim[pabov_pkg::FP_HI:pabov_pkg::FP_LO] = {4{display_drive_on_i}};
    assign pa_claim[3] = display_drive_on_i &
                         (display_duty_select_i > pabov_pkg::BP3_ABOVE);
    assign pa_claim[2] = display_drive_on_i &
                         (display_duty_select_i > pabov_pkg::BP2_ABOVE);
    assign pa_claim[1] = display_drive_on_i &
                         (display_duty_select_i > pabov_pkg::BP1_ABOVE);
    assign pa_claim[0] = display_drive_on_i;
    assign pa_zero = '0;

    // claimed pads switch to the analog segment / common line
    assign analog_pad_link_o = pa_claim;

    // claimed pins: all three overrides on with value 0, no port value override
    pabov_pin_ctrl #(
        .W(W)
    ) u_port_a (
        .dir_i(port_a_dir_i),
        .out_i(port_a_out_i),
        .pullup_disable_all_i(pullup_disable_all_i),
        .sleep_i(sleep_i),
        .pullup_ovr_enable_i(pa_claim),
        .pullup_ovr_value_i(pa_zero),
        .dir_ovr_enable_i(pa_claim),
        .dir_ovr_value_i(pa_zero),
        .value_ovr_enable_i(pa_zero),
        .value_ovr_value_i(pa_zero),
        .input_en_ovr_enable_i(pa_claim),
        .input_en_ovr_value_i(pa_zero),
        .pull_en_o(pa_pull_o),
        .drv_en_o(pa_pad_oe_o),
        .pad_val_o(pa_pad_o),
        .in_en_o(pa_in_en_o)
    );

    // ****************************************************************
    // port b: timers, spi, pin change
    // ****************************************************************
    logic spi_mst;
    logic spi_slv;
    logic [W-1:0] pb_pull_ovr_en;
    logic [W-1:0] pb_pull_ovr_val;
    logic [W-1:0] pb_dir_ovr_en;
    logic [W-1:0] pb_val_ovr_en;
    logic [W-1:0] pb_val_ovr_val;
    logic [W-1:0] pb_in_ovr_en;

    // no register in the role decode, so pins follow spi role changes at once
    assign spi_mst = spi_enable_i & spi_master_i;
    assign spi_slv = spi_enable_i & ~spi_master_i;

    // the master input is b3, the slave inputs are b2..b0
    assign pb_pull_ovr_en = {4'h0, spi_mst, {3{spi_slv}}};
    assign pb_dir_ovr_en = pb_pull_ovr_en;
    // forced inputs keep their pull-up under the port bit
    assign pb_pull_ovr_val = port_b_out_i & {W{~pullup_disable_all_i}};

    // compare enables steer the value; the driver stays with the direction bit,
    // so a compare output reaches the pad only on a pin set as output
    assign pb_val_ovr_en = {tmr_cmp_en_i, spi_slv, spi_mst,
        spi_mst, 1'b0};
    // the timers drive compare and pwm waveforms on the same lines
    assign pb_val_ovr_val = {timer2_cmp_a_out_i, timer1_cmp_b_out_i,
        timer1_cmp_a_out_i, timer0_cmp_a_out_i,
        spi_slave_out_i, spi_master_out_i, spi_sck_out_i, 1'b0};

    // pin-change sources keep their input alive in sleep
    assign pb_in_ovr_en = pin_change_mask_i & {W{pin_change_group_en_i}};

    pabov_pin_ctrl #(
        .W(W)
    ) u_port_b (
        .dir_i(port_b_dir_i),
        .out_i(port_b_out_i),
        .pullup_disable_all_i(pullup_disable_all_i),
        .sleep_i(sleep_i),
        .pullup_ovr_enable_i(pb_pull_ovr_en),
        .pullup_ovr_value_i(pb_pull_ovr_val),
        .dir_ovr_enable_i(pb_dir_ovr_en),
        .dir_ovr_value_i(pa_zero),
        .value_ovr_enable_i(pb_val_ovr_en),
        .value_ovr_value_i(pb_val_ovr_val),
        .input_en_ovr_enable_i(pb_in_ovr_en),
        .input_en_ovr_value_i(pb_in_ovr_en),
        .pull_en_o(pb_pull_o),
        .drv_en_o(pb_pad_oe_o),
        .pad_val_o(pb_pad_o),
        .in_en_o(pb_in_en_o)
    );

    // ****************************************************************
    // pad input synchronizers
    // ****************************************************************
    logic [W-1:0] pa_meta_reg;
    logic [W-1:0] pa_sync_reg;
    logic [W-1:0] pb_meta_reg;
    logic [W-1:0] pb_sync_reg;
    logic [W-1:0] pa_pin_reg;
    logic [W-1:0] pb_pin_reg;

    // two stages; the first is read only by the second
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pa_meta_reg <= pabov_pkg::SYNC_RST;
            pa_sync_reg <= pabov_pkg::SYNC_RST;
            pb_meta_reg <= pabov_pkg::SYNC_RST;
            pb_sync_reg <= pabov_pkg::SYNC_RST;
        end else begin
            pa_meta_reg <= pa_pad_i;
            pa_sync_reg <= pa_meta_reg;
            pb_meta_reg <= pb_pad_i;
            pb_sync_reg <= pb_meta_reg;
        end
    end

    // clamp after the synchronizer; a disabled input reads low, so a floating
    // analog pad never toggles pin-change or spi logic
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pa_pin_reg <= pabov_pkg::SYNC_RST;
            pb_pin_reg <= pabov_pkg::SYNC_RST;
        end else begin
            pa_pin_reg <= pa_sync_reg & pa_in_en_o;
            pb_pin_reg <= pb_sync_reg & pb_in_en_o;
        end
    end

    assign pa_pin_o = pa_pin_reg;
    assign pb_pin_o = pb_pin_reg;
    assign pin_change_src_o = pb_pin_reg;
    assign spi_master_in_o = pb_pin_reg[pabov_pkg::PB_MISO];
    assign spi_slave_in_o = pb_pin_reg[pabov_pkg::PB_MOSI];
    assign spi_sck_in_o = pb_pin_reg[pabov_pkg::PB_SCK];
    assign spi_select_in_o = pb_pin_reg[pabov_pkg::PB_SS];

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [1:0] warm_reg;

    // history depth counter so pipeline checks skip the reset shadow
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            warm_reg <= pabov_pkg::WARM_RST;
        end else if (warm_reg != pabov_pkg::WARM_DONE) begin
            warm_reg <= warm_reg + 2'h1;
        end
    end

    property p_fp_claim;
        @(posedge mclk_i) disable iff (rst_i)
        display_drive_on_i |-> (pa_pull_o[7:4] == 4'h0) && (pa_pad_oe_o[7:4] == 4'h0)
            && (pa_in_en_o[7:4] == 4'h0) && (analog_pad_link_o[7:4] == 4'hf)
            && (pa_pad_o[7:4] == port_a_out_i[7:4]);
    endproperty
    a_fp_claim: assert property (p_fp_claim) else $error("front-plane pins not claimed");

    property p_bp_duty;
        @(posedge mclk_i) disable iff (rst_i)
        analog_pad_link_o[3:0] == (display_drive_on_i ?
            ((display_duty_select_i == 2'h0) ? 4'h1 : (display_duty_select_i == 2'h1) ?
             4'h3 : (display_duty_select_i == 2'h2) ? 4'h7 : 4'hf) : 4'h0);
    endproperty
    a_bp_duty: assert property (p_bp_duty) else $error("back-plane claim wrong for duty");

    property p_bp_off;
        @(posedge mclk_i) disable iff (rst_i)
        (display_drive_on_i && display_duty_select_i == 2'h3) |->
            (pa_pull_o[3:0] | pa_pad_oe_o[3:0] | pa_in_en_o[3:0]) == 4'h0;
    endproperty
    a_bp_off: assert property (p_bp_off) else $error("claimed back-plane pin not off");

    property p_t2a;
        @(posedge mclk_i) disable iff (rst_i)
        (tmr_cmp_en_i[3] && port_b_dir_i[7]) |->
            pb_pad_oe_o[7] && (pb_pad_o[7] == timer2_cmp_a_out_i);
    endproperty
    a_t2a: assert property (p_t2a) else $error("timer2 a not on b7");

    property p_t1b;
        @(posedge mclk_i) disable iff (rst_i)
        (tmr_cmp_en_i[2] && port_b_dir_i[6]) |->
            pb_pad_oe_o[6] && (pb_pad_o[6] == timer1_cmp_b_out_i);
    endproperty
    a_t1b: assert property (p_t1b) else $error("timer1 b not on b6");

    property p_t1a;
        @(posedge mclk_i) disable iff (rst_i)
        (tmr_cmp_en_i[1] && port_b_dir_i[5]) |->
            pb_pad_oe_o[5] && (pb_pad_o[5] == timer1_cmp_a_out_i);
    endproperty
    a_t1a: assert property (p_t1a) else $error("timer1 a not on b5");

    property p_t0a;
        @(posedge mclk_i) disable iff (rst_i)
        (tmr_cmp_en_i[0] && port_b_dir_i[4]) |->
            pb_pad_oe_o[4] && (pb_pad_o[4] == timer0_cmp_a_out_i);
    endproperty
    a_t0a: assert property (p_t0a) else $error("timer0 a on b4 wrong");

    property p_pcint;
        @(posedge mclk_i) disable iff (rst_i)
        (warm_reg == pabov_pkg::WARM_DONE) |->
            pin_change_src_o == ($past(pb_pad_i, 3) & $past(pb_in_en_o, 1));
    endproperty
    a_pcint: assert property (p_pcint) else $error("pin-change source mismatch");

    property p_miso_mst;
        @(posedge mclk_i) disable iff (rst_i)
        spi_mst |-> !pb_pad_oe_o[3]
            && (pb_pull_o[3] == (port_b_out_i[3] && !pullup_disable_all_i));
    endproperty
    a_miso_mst: assert property (p_miso_mst) else $error("b3 not master input");

    property p_miso_slv;
        @(posedge mclk_i) disable iff (rst_i)
        spi_slv |-> (pb_pad_oe_o[3] == port_b_dir_i[3]) && (pb_pad_o[3] == spi_slave_out_i);
    endproperty
    a_miso_slv: assert property (p_miso_slv) else $error("b3 slave output wrong");

    property p_spi_mst_out;
        @(posedge mclk_i) disable iff (rst_i)
        spi_mst |-> (pb_pad_o[2] == spi_master_out_i) && (pb_pad_o[1] == spi_sck_out_i)
            && (pb_pad_oe_o[2:0] == port_b_dir_i[2:0]);
    endproperty
    a_spi_mst_out: assert property (p_spi_mst_out) else $error("spi master outputs wrong");

    property p_pa_default;
        @(posedge mclk_i) disable iff (rst_i)
        !display_drive_on_i |-> (pa_pad_oe_o == port_a_dir_i) && (pa_in_en_o == {8{!sleep_i}})
            && (pa_pull_o == (~port_a_dir_i & port_a_out_i & {8{!pullup_disable_all_i}}));
    endproperty
    a_pa_default: assert property (p_pa_default) else $error("port a defaults wrong");

    property p_same_cycle;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(display_drive_on_i) |-> (pa_pad_oe_o[0] == 1'b0) && analog_pad_link_o[0];
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("ownership change lagged");

endmodule

`default_nettype wire

// File: dv/pabov_pad_model.sv
// pad model: own driver, outside driver, pull-up and a wandering floating level
`timescale 1ns/10ps
`default_nettype none

module pabov_pad_model (
    input wire logic mclk_i,
    input wire logic [7:0] pad_val_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pull_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] level_o
);
    logic [7:0] float_reg = 8'h55;

    // a floating pad never keeps its last level, so it flips every cycle
    always @(negedge mclk_i) begin
        float_reg <= ~float_reg;
    end

    // own driver wins, then the outside driver, then the pull-up
    always_comb begin
        level_o = (pad_oe_i & pad_val_i) | (~pad_oe_i & ext_en_i & ext_val_i)
            | (~pad_oe_i & ~ext_en_i & (pull_i | float_reg));
    end
endmodule

`default_nettype wire

// File: dv/pabov_top_tb.sv
// self-checking bench for the port a / port b override block
`timescale 1ns/10ps
`default_nettype none

module pabov_top_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep, pullup_disable_all, lcd, spe, mst, grp, t2a, t1b, t1a, t0a, sso, smo, sck;
    logic [1:0] duty;
    logic [3:0] tce;
    logic [7:0] adir, aout, bdir, bout, mask, aee, aev, bee, bev, pa_lvl, pb_lvl;
    logic [7:0] pa_o, pa_oe, pa_pu, pa_ie, alink, pb_o, pb_oe, pb_pu, pb_ie;
    logic [7:0] pa_pin, pb_pin, pcs;
    logic smi, sli, ski, ssl;
    logic [7:0] e_claim, e_apu, e_aoe, e_aie, e_bpu, e_boe, e_bval, e_bie;
    logic [7:0] ha[3];
    logic [7:0] hb[3];
    logic [7:0] hea;
    logic [7:0] heb;
    int n_rel = -1;
    int fails = 0;
    int checks = 0;

    // ****************************************************************
    // clock, design and pads
    // ****************************************************************
    always #20 mclk_i = ~mclk_i;

    pabov_top pabov_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .sleep_i(sleep),
        .pullup_disable_all_i(pullup_disable_all), .port_a_dir_i(adir), .port_a_out_i(aout),
        .port_b_dir_i(bdir), .port_b_out_i(bout), .display_drive_on_i(lcd),
        .display_duty_select_i(duty), .tmr_cmp_en_i(tce), .timer2_cmp_a_out_i(t2a),
        .timer1_cmp_b_out_i(t1b), .timer1_cmp_a_out_i(t1a), .timer0_cmp_a_out_i(t0a),
        .spi_enable_i(spe), .spi_master_i(mst), .spi_slave_out_i(sso),
        .spi_master_out_i(smo), .spi_sck_out_i(sck), .pin_change_group_en_i(grp),
        .pin_change_mask_i(mask), .pa_pad_i(pa_lvl), .pb_pad_i(pb_lvl),
        .pa_pad_o(pa_o), .pa_pad_oe_o(pa_oe), .pa_pull_o(pa_pu), .pa_in_en_o(pa_ie),
        .analog_pad_link_o(alink), .pb_pad_o(pb_o), .pb_pad_oe_o(pb_oe),
        .pb_pull_o(pb_pu), .pb_in_en_o(pb_ie), .pa_pin_o(pa_pin), .pb_pin_o(pb_pin),
        .pin_change_src_o(pcs), .spi_master_in_o(smi), .spi_slave_in_o(sli),
        .spi_sck_in_o(ski), .spi_select_in_o(ssl));

    pabov_pad_model pad_a_i (.mclk_i(mclk_i), .pad_val_i(pa_o), .pad_oe_i(pa_oe),
        .pull_i(pa_pu), .ext_en_i(aee), .ext_val_i(aev), .level_o(pa_lvl));
    pabov_pad_model pad_b_i (.mclk_i(mclk_i), .pad_val_i(pb_o), .pad_oe_i(pb_oe),
        .pull_i(pb_pu), .ext_en_i(bee), .ext_val_i(bev), .level_o(pb_lvl));

    // ****************************************************************
    // reference model and history
    // ****************************************************************
    // expected pad controls from the current control bits
    task automatic model();
        logic s;
        logic m;
        logic [7:0] pull_ovr;
        logic [7:0] val_ovr;
        s = spe & ~mst;
        m = spe & mst;
        e_claim = {{4{lcd}}, lcd & (duty > 2'h2), lcd & (duty > 2'h1), lcd & (duty > 2'h0), lcd};
        e_apu = ~e_claim & ~adir & aout & {8{~pullup_disable_all}};
        e_aoe = ~e_claim & adir;
        e_aie = ~e_claim & {8{~sleep}};
        pull_ovr = {4'h0, m, s, s, s};
        e_bpu = (pull_ovr | ~bdir) & bout & {8{~pullup_disable_all}};
        e_boe = ~pull_ovr & bdir;
        val_ovr = {tce, s, m, m, 1'b0};
        e_bval = (val_ovr & {t2a, t1b, t1a, t0a, sso, smo, sck, 1'b0}) | (~val_ovr & bout);
        e_bie = (mask & {8{grp}}) | {8{~sleep}};
    endtask

    // pad levels and input enables seen at each edge, for the synchronizer path
    always @(posedge mclk_i) begin
        if (rst_i) n_rel = 0;
        else if (n_rel >= 0 && n_rel < 9) n_rel++;
        ha[2] = ha[1];
        ha[1] = ha[0];
        ha[0] = pa_lvl;
        hb[2] = hb[1];
        hb[1] = hb[0];
        hb[0] = pb_lvl;
        hea = e_aie;
        heb = e_bie;
    end

    // ****************************************************************
    // compares and sequencing
    // ****************************************************************
    task automatic cmp_comb(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t pad control %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_reg(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t sampled %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_reg();
        logic [7:0] eb;
        eb = hb[2] & heb;
        if (n_rel == 0) begin
            cmp_reg("a pin reset", pa_pin, 8'h00);
            cmp_reg("b pin reset", pb_pin, 8'h00);
        end else if (n_rel >= 3) begin
            // the clamp uses the enable standing at the sampling edge itself
            cmp_reg("a pin", pa_pin, ha[2] & hea);
            cmp_reg("b pin", pb_pin, eb);
            cmp_reg("pin change", pcs, eb);
            cmp_reg("spi in", {4'h0, smi, sli, ski, ssl}, {4'h0, eb[3:0]});
        end
    endtask

    // inputs were just set after a falling edge: check now, then hold
    task automatic go(input int hold);
        #2;
        model();
        cmp_comb("a link", alink, e_claim);
        cmp_comb("a pull", pa_pu, e_apu);
        cmp_comb("a drive", pa_oe, e_aoe);
        cmp_comb("a in", pa_ie, e_aie);
        cmp_comb("a val", pa_o, aout);
        cmp_comb("b pull", pb_pu, e_bpu);
        cmp_comb("b drive", pb_oe, e_boe);
        cmp_comb("b val", pb_o, e_bval);
        cmp_comb("b in", pb_ie, e_bie);
        repeat (hold) begin
            @(negedge mclk_i);
            chk_reg();
        end
    endtask

    task automatic rand_in();
        {sleep, pullup_disable_all, lcd, spe, mst, grp, t2a, t1b, t1a, t0a, sso, smo, sck} = 13'($urandom);
        duty = 2'($urandom);
        tce = 4'($urandom);
        {adir, aout, bdir, bout} = $urandom;
        {mask, aee, aev, bee} = $urandom;
        bev = 8'($urandom);
    endtask

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'h6f6a6193));
        rand_in();
        model();
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        go(4);
        // every duty setting with the display on
        for (int d = 0; d < 4; d++) begin
            rand_in();
            lcd = 1'b1;
            duty = 2'(d);
            go(3);
        end
        // every spi enable / role pairing
        for (int k = 0; k < 4; k++) begin
            rand_in();
            spe = k[0];
            mst = k[1];
            go(3);
        end
        repeat (300) begin
            rand_in();
            go(int'($urandom_range(1, 4)));
        end
        // reset again in mid-run: sampled levels clear, controls keep following
        rst_i = 1'b1;
        go(2);
        rst_i = 1'b0;
        repeat (40) begin
            rand_in();
            go(int'($urandom_range(1, 4)));
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
